// ### rtl/hpsp_ctrl.sv
// Port strap sampling, upstream attach pull-up and downstream port power control.
// Operation
// [R01] Names ending _n are low-active, others high.
// [R02] Enable upstream pull-up only with supply present.
// [R03] Sample port disable straps when strap mode enabled.
// [R04] Board ties both data pins high to disable.
// [R05] One active-high power enable per downstream port.
// [R06] Straps captured at reset negation instant; the code takes them from sync2 on the third clock edge after release.
// [R07] Disabled port stays unpowered until next reset.
`timescale 1ns/1ns
module hpsp_ctrl
	import hpsp_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic upstream_supply_detect,
	input wire logic strap_enable,
	input wire hpsp_strap_t port_off_strap,
	input wire logic [HPSP_PORTS-1:0] port_power_request,
	output logic upstream_pullup_enable,
	output logic [HPSP_PORTS-1:0] port_power_enable,
	output logic [HPSP_PORTS-1:0] port_disabled
);
	// Pin inputs pass two flip-flops; stage one feeds only stage two.
	hpsp_pins_t sync1;
	hpsp_pins_t sync2;
	hpsp_state_t state;
	hpsp_state_t next_state;
	logic [HPSP_PORTS-1:0] next_disabled;
	logic [HPSP_PORTS-1:0] next_power;
	logic next_pullup;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1 <= 10'h000;
			sync2 <= 10'h000;
		end
		else
		begin
			sync1.supply <= upstream_supply_detect;
			sync1.strap_en <= strap_enable;
			sync1.strap <= port_off_strap;
			sync2 <= sync1;
		end
	end

	// Both pins high marks the port off; one high pin alone is an ordinary line state of an
	// attached device, so it must not switch the port off. see [R04]
	function automatic logic [HPSP_PORTS-1:0] strap_off(
		input logic strap_en,
		input hpsp_strap_t pins
	);
		logic [HPSP_PORTS-1:0] off;
		off = pins.pos & pins.neg;
		return strap_en ? off : 4'h0;
	endfunction

	// The synchroniser is cleared by reset, so the straps only stand in sync2 two edges after
	// release; the capture waits in a fill state and lands on the third edge.
	always_comb
	begin
		next_state = state;
		next_disabled = port_disabled;
		next_power = port_power_enable;
		next_pullup = sync2.supply && (state == HPSP_ST_RUN); // see [R02]
		case (state)
			HPSP_ST_RESET:
			begin
				next_state = HPSP_ST_FILL;
			end
			HPSP_ST_FILL:
			begin
				next_state = HPSP_ST_SAMPLE;
			end
			HPSP_ST_SAMPLE:
			begin
				next_state = HPSP_ST_RUN;
				next_disabled = strap_off(sync2.strap_en, sync2.strap); // see [R03] see [R06]
				next_power = 4'h0;
			end
			HPSP_ST_RUN:
			begin
				next_power = port_power_request & ~port_disabled; // see [R05] see [R07]
			end
			default:
			begin
				next_state = HPSP_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) // see [R01]
	begin
		if (!arst_n)
		begin
			state <= HPSP_ST_RESET;
			port_disabled <= HPSP_RST_DISABLED;
			port_power_enable <= HPSP_RST_POWER;
			upstream_pullup_enable <= HPSP_RST_PULLUP;
		end
		else
		begin
			state <= next_state;
			port_disabled <= next_disabled;
			port_power_enable <= next_power;
			upstream_pullup_enable <= next_pullup;
		end
	end

	property p_disabled_unpowered;
		@(posedge clk) disable iff (!arst_n)
		(state == HPSP_ST_RUN) |=> ((port_power_enable & port_disabled) == 4'h0);
	endproperty
	a_disabled_unpowered: assert property (p_disabled_unpowered) // see [R07]
		else $error("Disabled port powered.");

	property p_disabled_stable;
		@(posedge clk) disable iff (!arst_n)
		(state == HPSP_ST_RUN) |=> $stable(port_disabled);
	endproperty
	a_disabled_stable: assert property (p_disabled_stable) // see [R07]
		else $error("Disable changed after sample.");

	property p_sample;
		@(posedge clk) disable iff (!arst_n)
		(state == HPSP_ST_SAMPLE) |=>
			(port_disabled == strap_off($past(sync2.strap_en), $past(sync2.strap)));
	endproperty
	a_sample: assert property (p_sample) // see [R03]
		else $error("Strap sample wrong.");

	property p_pullup;
		@(posedge clk) disable iff (!arst_n)
		upstream_pullup_enable |-> $past(sync2.supply);
	endproperty
	a_pullup: assert property (p_pullup) // see [R02]
		else $error("Pull-up without supply.");

	property p_pullup_on;
		@(posedge clk) disable iff (!arst_n)
		(sync2.supply && state == HPSP_ST_RUN) |=> upstream_pullup_enable;
	endproperty
	a_pullup_on: assert property (p_pullup_on) // see [R02]
		else $error("Pull-up missing.");

	property p_power_follows;
		@(posedge clk) disable iff (!arst_n)
		(state == HPSP_ST_RUN) |=> (port_power_enable == ($past(port_power_request) & ~port_disabled));
	endproperty
	a_power_follows: assert property (p_power_follows) // see [R05]
		else $error("Power enable wrong.");

	// Anchored on the fill state: reset is released on a clock edge, so an attempt that starts
	// in the reset state at that edge would see the reset state once more at the next one.
	property p_sequence;
		@(posedge clk) disable iff (!arst_n)
		(state == HPSP_ST_FILL) |=> (state == HPSP_ST_SAMPLE) ##1 (state == HPSP_ST_RUN);
	endproperty
	a_sequence: assert property (p_sequence) // see [R06]
		else $error("Sample sequence broken.");

	property p_no_power_early;
		@(posedge clk) disable iff (!arst_n)
		(state != HPSP_ST_RUN) |-> (port_power_enable == 4'h0 && !upstream_pullup_enable);
	endproperty
	a_no_power_early: assert property (p_no_power_early) // see [R05]
		else $error("Output active before run.");

	property p_strap_ignored;
		@(posedge clk) disable iff (!arst_n)
		(state == HPSP_ST_SAMPLE && !sync2.strap_en) |=> (port_disabled == 4'h0);
	endproperty
	a_strap_ignored: assert property (p_strap_ignored) // see [R03]
		else $error("Port disabled with straps off.");

	property p_disabled_held;
		@(posedge clk) disable iff (!arst_n)
		(state == HPSP_ST_FILL) |=> (port_disabled == HPSP_RST_DISABLED);
	endproperty
	a_disabled_held: assert property (p_disabled_held) // see [R06]
		else $error("Disable taken before sample.");

	property p_pullup_off;
		@(posedge clk) disable iff (!arst_n)
		!sync2.supply |=> !upstream_pullup_enable;
	endproperty
	a_pullup_off: assert property (p_pullup_off) // see [R02]
		else $error("Pull-up kept without supply.");

	property p_run_holds;
		@(posedge clk) disable iff (!arst_n)
		(state == HPSP_ST_RUN) |=> (state == HPSP_ST_RUN);
	endproperty
	a_run_holds: assert property (p_run_holds) // see [R07]
		else $error("Run left without reset.");

	property p_pullup_run;
		@(posedge clk) disable iff (!arst_n)
		upstream_pullup_enable |-> $past(state == HPSP_ST_RUN);
	endproperty
	a_pullup_run: assert property (p_pullup_run) // see [R02]
		else $error("Pull-up before run.");

	// Three checkers per port, so a failure points at the port that broke the rule.
	for (genvar i = 0; i < HPSP_PORTS; i++)
	begin : g_port
		property p_port_off;
			@(posedge clk) disable iff (!arst_n)
			port_disabled[i] |-> !port_power_enable[i];
		endproperty
		a_port_off: assert property (p_port_off) // see [R07]
			else $error("Disabled port has power.");

		property p_port_on;
			@(posedge clk) disable iff (!arst_n)
			(state == HPSP_ST_RUN && port_power_request[i] && !port_disabled[i]) |=>
				port_power_enable[i];
		endproperty
		a_port_on: assert property (p_port_on) // see [R05]
			else $error("Requested port not powered.");

		property p_port_drop;
			@(posedge clk) disable iff (!arst_n)
			!port_power_request[i] |=> !port_power_enable[i];
		endproperty
		a_port_drop: assert property (p_port_drop) // see [R05]
			else $error("Port powered without request.");
	end

endmodule // hpsp_ctrl

// ### rtl/hpsp_pkg.sv
// Package of shared types and constants for the hub port strap and power control block.
package hpsp_pkg;
	localparam int HPSP_PORTS = 4;
	localparam logic [3:0] HPSP_RST_POWER = 4'h0;
	localparam logic [3:0] HPSP_RST_DISABLED = 4'h0;
	localparam logic HPSP_RST_PULLUP = 1'h0;

	typedef enum {HPSP_ST_RESET, HPSP_ST_FILL, HPSP_ST_SAMPLE, HPSP_ST_RUN} hpsp_state_t;

	typedef struct packed {
		logic [3:0] pos;
		logic [3:0] neg;
	} hpsp_strap_t;

	typedef struct packed {
		logic supply;
		logic strap_en;
		hpsp_strap_t strap;
	} hpsp_pins_t;
endpackage

// ### verif/hpsp_board.sv
// Board model driving the strap levels onto the downstream data pins.
`timescale 1ns/1ns
module hpsp_board
	import hpsp_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire hpsp_strap_t strap,
	output hpsp_strap_t pins
);
	int held;
	bit [7:0] noise;
	always @(posedge clk or negedge arst_n)
		if (!arst_n)
			held <= 0;
		else if (held < 3)
			held <= held + 1;
	always @(posedge clk)
		noise <= noise + 8'h5B;
	// Straps stand until three edges after release; after that the pins carry traffic that keeps changing.
	assign pins = (held < 3) ? strap : noise;
endmodule // hpsp_board

// ### verif/hub_port_strap_and_power_ctrl_tb.sv
// Self-checking bench for the hub port strap and power control block.
`timescale 1ns/1ns
`define HPSP_CMP(n, e, s) check_count++; if ((e) !== (s)) miss(n, e, s);
module hub_port_strap_and_power_ctrl_tb
	import hpsp_pkg::*;
;
	logic clk = 0, arst_n = 0, supply = 0, en = 0, pull;
	hpsp_strap_t strap = '0, pins, ns;
	logic [3:0] req = 4'h0, pwr, dis, exp_dis = 4'h0, req_d = 4'h0;
	int fails = 0, check_count = 0, cyc = 0, live = 0, sup_q[$];
	bit [31:0] seed = 40914;
	function automatic bit [31:0] xs(input bit [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic miss(string n, logic [3:0] e, logic [3:0] s);
		fails++;
		$display("unexpected %s expected %h seen %h", n, e, s);
	endtask
	task automatic wrap_up();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial forever #10 clk = ~clk;
	hpsp_board board (.clk(clk), .arst_n(arst_n), .strap(strap), .pins(pins));
	hpsp_ctrl DUT (.clk(clk), .arst_n(arst_n), .upstream_supply_detect(supply),
		.strap_enable(en), .port_off_strap(pins), .port_power_request(req),
		.upstream_pullup_enable(pull), .port_power_enable(pwr), .port_disabled(dis));
	// The queue gives the pin level three edges back, matching the two-stage synchroniser plus the pull-up output register.
	always @(negedge clk)
	begin
		if (live)
		begin
			`HPSP_CMP("disabled", exp_dis, dis)
			`HPSP_CMP("power", req_d & ~exp_dis, pwr)
			`HPSP_CMP("pullup", {3'h0, sup_q[0][0]}, {3'h0, pull})
		end
		req_d = req;
		sup_q.push_back(supply);
		if (sup_q.size() > 3)
			void'(sup_q.pop_front());
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			wrap_up();
		end
	end
	// Every round after the first resets in mid-run, so later rounds also prove the straps are taken again.
	initial
	begin
		for (int r = 0; r < 3; r++)
		begin
			live = 0;
			seed = xs(seed);
			ns = (r == 2) ? 8'hFF : seed[7:0];
			exp_dis = (r != 1) ? ns.pos & ns.neg : 4'h0;
			@(posedge clk);
			arst_n <= 0;
			strap <= ns;
			en <= (r != 1);
			repeat (10) @(posedge clk);
			arst_n <= 1;
			repeat (6) @(posedge clk);
			live = 1;
			repeat (300) @(posedge clk)
			begin
				seed = xs(seed);
				req <= seed[3:0];
				supply <= seed[8];
			end
		end
		wrap_up();
	end
endmodule // hub_port_strap_and_power_ctrl_tb
